// ===== bench/but_timer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module but_timer_checker
  import but_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  // requests and trigger
  input wire logic irq_o,
  input wire logic dma_req_o,
  input wire logic trigger_out_o
);
  logic [TRG_W-1:0] trg;
  logic irq_en;
  logic dma_en;
  logic frc;
  // ****************************************
  // shadow copies of software settings
  // ****************************************
  assign frc = wr_i && addr_i == OFS_EVENT_TRIGGER && wdata_i[EGR_FORCE_BIT];
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      trg <= '0;
    else if (wr_i && addr_i == OFS_CONTROL_SECONDARY)
      trg <= wdata_i[CR2_TRG_LSB +: TRG_W];
  end
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      irq_en <= 1'b0;
      dma_en <= 1'b0;
    end
    else if (wr_i && addr_i == OFS_IRQ_DMA_ENABLES)
    begin
      irq_en <= wdata_i[EN_IRQ_BIT];
      dma_en <= wdata_i[EN_DMA_BIT];
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_rd_idle;
    !rd_i |=> rdata_o == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_force_reads_zero;
    rd_i && addr_i == OFS_EVENT_TRIGGER |=> rdata_o == '0;
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero) else $error("force bit read");
  property p_trg_read;
    rd_i && addr_i == OFS_CONTROL_SECONDARY |=> rdata_o == {25'h0, $past(trg), 4'h0};
  endproperty
  a_trg_read: assert property (p_trg_read) else $error("trigger select readback");
  property p_en_read;
    rd_i && addr_i == OFS_IRQ_DMA_ENABLES |=>
      rdata_o == {23'h0, $past(dma_en), 7'h0, $past(irq_en)};
  endproperty
  a_en_read: assert property (p_en_read) else $error("enable readback");
  property p_irq_gate;
    irq_o |-> $past(irq_en);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
  property p_dma_gate;
    dma_req_o |-> $past(dma_en);
  endproperty
  a_dma_gate: assert property (p_dma_gate) else $error("dma while disabled");
  property p_force_trg;
    frc && trg == TRG_FORCE |=> trigger_out_o;
  endproperty
  a_force_trg: assert property (p_force_trg) else $error("force pulse missing");
  property p_force_only;
    !frc && trg == TRG_FORCE |=> !trigger_out_o;
  endproperty
  a_force_only: assert property (p_force_only) else $error("stray force pulse");
  property p_spare_code;
    trg > TRG_UPDATE |=> !trigger_out_o;
  endproperty
  a_spare_code: assert property (p_spare_code) else $error("spare code drives");
endmodule : but_timer_checker
bind but_timer but_timer_checker u_chk (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .irq_o, .dma_req_o, .trigger_out_o);
`default_nettype wire

// ===== bench/but_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module but_timer_tb_top
  import but_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic debug_halt_i = 1'b0;
  logic halt_freeze_select_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic irq_o;
  logic dma_req_o;
  logic trigger_out_o;
  int n_errors = 0;
  int tests_run = 0;
  int k;
  logic [DATA_W-1:0] d;
  logic [ADDR_W-1:0] tz [10] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h24, 8'h28, 8'h2c,
    8'h08, 8'h30};
  logic [ADDR_W-1:0] ta [6] = '{8'h00, 8'h04, 8'h0c, 8'h24, 8'h28, 8'h2c};
  logic [DATA_W-1:0] te [6] = '{32'h0000_008e, 32'h0000_0070, 32'h0000_0100, 32'hffff_fffe,
    32'h0000_fffe, 32'hffff_fffe};
  always #2 clk_i = ~clk_i;
  but_timer DUT (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .debug_halt_i, .halt_freeze_select_i, .irq_o, .dma_req_o, .trigger_out_o);
  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd
  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    tests_run++;
    if (g !== e)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      n_errors++;
    end
  endtask : chk
  // bounded wait, so a dead timer cannot hang the run
  task automatic to_pulse(output int n);
    n = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    while (dma_req_o !== 1'b1 && n < 4000);
    // a run that never reaches the request counts as a mismatch here
    chk(dma_req_o, 1'b1);
  endtask : to_pulse
  task automatic pulses(output int n);
    n = 0;
    repeat (40)
    begin
      @(posedge clk_i);
      #1;
      if (dma_req_o === 1'b1)
        n++;
    end
  endtask : pulses
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  initial
  begin
    #200000;
    n_errors++;
    finish_test();
  end
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    foreach (tz[i])
    begin
      rd(tz[i], d);
      chk(d, 32'h0000_0000);
    end
    foreach (ta[i])
    begin
      wr(ta[i], 32'hffff_fffe);
      rd(ta[i], d);
      chk(d, te[i]);
    end
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    $display("test registers done");
    wr(8'h0c, 32'h0000_0101);
    wr(8'h28, 32'h0000_0003);
    wr(8'h2c, 32'h0000_0001);
    wr(8'h14, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    #1;
    chk(irq_o, 1'b1);
    wr(8'h0c, 32'h0000_0100);
    @(posedge clk_i);
    #1;
    chk(irq_o, 1'b0);
    wr(8'h0c, 32'h0000_0101);
    wr(8'h10, 32'h0000_0001);
    rd(8'h10, d);
    chk(d, 32'h0000_0001);
    wr(8'h10, 32'h0);
    rd(8'h10, d);
    chk(d, 32'h0);
    chk(irq_o, 1'b0);
    $display("test flag and irq done");
    wr(8'h00, 32'h0000_0001);
    to_pulse(k);
    to_pulse(k);
    chk(k, 8);
    wr(8'h28, 32'h0000_0001);
    to_pulse(k);
    chk(k > 4, 1'b1);
    to_pulse(k);
    chk(k, 4);
    wr(8'h2c, 32'h0000_0003);
    to_pulse(k);
    chk(k > 4, 1'b1);
    to_pulse(k);
    chk(k, 8);
    wr(8'h00, 32'h0000_0081);
    to_pulse(k);
    wr(8'h2c, 32'h0);
    to_pulse(k);
    chk(k > 2, 1'b1);
    to_pulse(k);
    chk(k, 2);
    rd(8'h2c, d);
    chk(d, 32'h0);
    $display("test counting done");
    @(posedge clk_i);
    debug_halt_i <= 1'b1;
    halt_freeze_select_i <= 1'b1;
    pulses(k);
    chk(k, 0);
    @(posedge clk_i);
    halt_freeze_select_i <= 1'b0;
    to_pulse(k);
    pulses(k);
    chk(k, 20);
    @(posedge clk_i);
    debug_halt_i <= 1'b0;
    wr(8'h00, 32'h0000_0083);
    pulses(k);
    chk(k, 0);
    wr(8'h00, 32'h0000_0002);
    wr(8'h24, 32'h0000_0007);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0000_0001);
    rd(8'h24, d);
    chk(d, 32'h0);
    rd(8'h10, d);
    chk(d, 32'h0);
    wr(8'h00, 32'h0000_0004);
    wr(8'h14, 32'h0000_0001);
    rd(8'h10, d);
    chk(d, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h0000_0001);
    rd(8'h10, d);
    chk(d, 32'h0000_0001);
    $display("test inhibit and source done");
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h04, DATA_W'(c) << CR2_TRG_LSB);
      wr(8'h00, 32'h0000_0001);
      @(posedge clk_i);
      #1;
      if (c == 1) chk(trigger_out_o, 1'b0);
      @(posedge clk_i);
      #1;
      if (c == 1) chk(trigger_out_o, 1'b1);
      wr(8'h14, 32'h0000_0001);
      #1;
      chk(trigger_out_o, DATA_W'(c != 3));
      wr(8'h00, 32'h0);
    end
    $display("test trigger done");
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h0000_0009);
    to_pulse(k);
    rd(8'h00, d);
    chk(d, 32'h0000_0008);
    pulses(k);
    chk(k, 0);
    $display("test single shot done");
    finish_test();
  end
endmodule : but_timer_tb_top
`default_nettype wire

// ===== inc/but_pkg.sv
// How it works
// - counter counts up from zero to active reload value, wraps, flags overflow
// - sixteen-bit prescaler divides the clock by division value plus one
// - division writes go to a buffer, applied at the next update event
// - reload copies through at once unless the reload buffer is enabled
// - register reads of reload return the preload copy; writes also reach the active copy unless the reload buffer is enabled
// - counting follows the run enable bit one clock cycle late
// - overflow or forced update makes an update event unless inhibited
// - inhibit blocks update events and shadow loads; forced update still clears counters
// - with source select set, forced update leaves pending flag alone
// - update event loads divider and reload shadow; sets pending flag unless forced with source select set
// - force update restarts counter and prescaler; bit reads back as zero
// - single shot mode clears run enable on the update event
// - control bit zero disables or enables the counter
// - prescaler runs from kernel clock one cycle after run enable is set
// - debug halt freezes counting when the freeze select input asks so
// - counter, division and reload are readable and writable while running
// - a trigger output is provided for the converter
// - overflow update events can raise interrupt and DMA requests
// - pending flag set by hardware, cleared by writing zero, one ignored
// - enable bit eight enables DMA request, bit zero the interrupt
// - trigger select 000 force pulse, 001 count active, 010 update event
// - tick rate is input clock over division value plus one
`default_nettype none
package but_pkg;

  localparam int unsigned CNT_W = 32;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_CONTROL_PRIMARY = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_SECONDARY = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_DMA_ENABLES = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EVENT_TRIGGER = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_COUNT_VALUE = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_DIVIDER = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_RELOAD_LIMIT = 8'h2c;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int unsigned CR1_RUN_BIT = 0;
  localparam int unsigned CR1_INHIBIT_BIT = 1;
  localparam int unsigned CR1_SOURCE_BIT = 2;
  localparam int unsigned CR1_SINGLE_BIT = 3;
  localparam int unsigned CR1_RELOAD_BUF_BIT = 7;
  localparam int unsigned CR2_TRG_LSB = 4;
  localparam int unsigned TRG_W = 3;
  localparam int unsigned EN_IRQ_BIT = 0;
  localparam int unsigned EN_DMA_BIT = 8;
  localparam int unsigned FLAG_PENDING_BIT = 0;
  localparam int unsigned EGR_FORCE_BIT = 0;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [CNT_W-1:0] RST_COUNT = 32'h0000_0000;
  localparam logic [DIV_W-1:0] RST_DIV = 16'h0000;

  // trigger source encodings
  localparam logic [TRG_W-1:0] TRG_FORCE = 3'h0;
  localparam logic [TRG_W-1:0] TRG_ACTIVE = 3'h1;
  localparam logic [TRG_W-1:0] TRG_UPDATE = 3'h2;

  typedef struct packed {
    logic reload_buffer_enable;
    logic single_shot_mode;
    logic update_source_select;
    logic update_inhibit;
    logic counter_run_enable;
  } but_ctrl_t;

  typedef struct packed {
    logic force_update;
    logic count_active;
    logic update_event;
  } but_evt_t;

endpackage : but_pkg
`default_nettype wire

// ===== verilog/but_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module but_prescaler
  import but_pkg::*;
#(
  parameter int unsigned W = DIV_W
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // control
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [W-1:0] ratio_i,
  // tick out
  output logic tick_o
);

  logic [W-1:0] div_count;

  // tick on the last step of each division period
  assign tick_o = run_i && !clear_i && (div_count == ratio_i);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      div_count <= '0;
    end
    else if (clear_i)
    begin
      div_count <= '0;
    end
    else if (run_i)
    begin
      // ratio of all ones divides by the full 2**W
      div_count <= tick_o ? '0 : W'(div_count + 1'b1);
    end
  end

endmodule : but_prescaler
`default_nettype wire

// ===== verilog/but_timer.sv
`timescale 1ns/1ps
`default_nettype none
module but_timer
  import but_pkg::*;
#(
  parameter int unsigned COUNT_W = CNT_W,
  parameter int unsigned DIVIDE_W = DIV_W
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // debug halt
  input wire logic debug_halt_i,
  input wire logic halt_freeze_select_i,
  // requests and trigger
  output logic irq_o,
  output logic dma_req_o,
  output logic trigger_out_o
);

  // ****************************************
  // register state
  // ****************************************
  but_ctrl_t ctrl;
  logic [TRG_W-1:0] trigger_source_select;
  logic update_irq_enable;
  logic update_dma_enable;
  logic update_pending_flag;
  logic [COUNT_W-1:0] count_value;
  logic [DIVIDE_W-1:0] division_buffer;
  logic [DIVIDE_W-1:0] division_active;
  logic [COUNT_W-1:0] reload_preload;
  logic [COUNT_W-1:0] reload_active;
  logic count_active;

  // ****************************************
  // decode
  // ****************************************
  logic wr_ctrl1;
  logic wr_ctrl2;
  logic wr_enables;
  logic wr_flags;
  logic wr_trigger;
  logic wr_count;
  logic wr_divider;
  logic wr_reload;

  assign wr_ctrl1 = wr_i && (addr_i == OFS_CONTROL_PRIMARY);
  assign wr_ctrl2 = wr_i && (addr_i == OFS_CONTROL_SECONDARY);
  assign wr_enables = wr_i && (addr_i == OFS_IRQ_DMA_ENABLES);
  assign wr_flags = wr_i && (addr_i == OFS_EVENT_FLAGS);
  assign wr_trigger = wr_i && (addr_i == OFS_EVENT_TRIGGER);
  assign wr_count = wr_i && (addr_i == OFS_COUNT_VALUE);
  assign wr_divider = wr_i && (addr_i == OFS_CLOCK_DIVIDER);
  assign wr_reload = wr_i && (addr_i == OFS_RELOAD_LIMIT);

  // ****************************************
  // events
  // ****************************************
  logic force_update;
  logic freeze;
  logic run;
  logic tick;
  logic overflow;
  logic update_event;
  logic set_pending;

  // the force bit is a pulse, so it never holds a stored one
  assign force_update = wr_trigger && wdata_i[EGR_FORCE_BIT];
  assign freeze = debug_halt_i && halt_freeze_select_i;
  assign run = count_active && !freeze;
  assign overflow = tick && (count_value == reload_active);
  assign update_event = !ctrl.update_inhibit && (overflow || force_update);
  // forced updates stay silent when only overflow may request service
  assign set_pending = !ctrl.update_inhibit
                       && (overflow || (force_update && !ctrl.update_source_select));

  but_prescaler #(
    .W(DIVIDE_W)
  ) u_prescaler (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .run_i(run),
    .clear_i(force_update),
    .ratio_i(division_active),
    .tick_o(tick)
  );

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl <= '0;
    end
    else if (wr_ctrl1)
    begin
      // a software write in the same cycle as the stop takes precedence
      ctrl.counter_run_enable <= wdata_i[CR1_RUN_BIT];
      ctrl.update_inhibit <= wdata_i[CR1_INHIBIT_BIT];
      ctrl.update_source_select <= wdata_i[CR1_SOURCE_BIT];
      ctrl.single_shot_mode <= wdata_i[CR1_SINGLE_BIT];
      ctrl.reload_buffer_enable <= wdata_i[CR1_RELOAD_BUF_BIT];
    end
    else if (update_event && ctrl.single_shot_mode)
    begin
      ctrl.counter_run_enable <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      trigger_source_select <= TRG_FORCE;
    end
    else if (wr_ctrl2)
    begin
      trigger_source_select <= wdata_i[CR2_TRG_LSB +: TRG_W];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      update_irq_enable <= 1'b0;
      update_dma_enable <= 1'b0;
    end
    else if (wr_enables)
    begin
      update_irq_enable <= wdata_i[EN_IRQ_BIT];
      update_dma_enable <= wdata_i[EN_DMA_BIT];
    end
  end

  // ****************************************
  // pending flag
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      update_pending_flag <= 1'b0;
    end
    else if (set_pending)
    begin
      // a new event beats a clear written in the same cycle
      update_pending_flag <= 1'b1;
    end
    else if (wr_flags && !wdata_i[FLAG_PENDING_BIT])
    begin
      update_pending_flag <= 1'b0;
    end
  end

  // ****************************************
  // count enable delay
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count_active <= 1'b0;
    end
    else
    begin
      // prescaler starts on the kernel clock one cycle after the bit
      count_active <= ctrl.counter_run_enable;
    end
  end

  // ****************************************
  // main counter
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count_value <= RST_COUNT;
    end
    else if (force_update)
    begin
      // restarts even while inhibited
      count_value <= RST_COUNT;
    end
    else if (wr_count)
    begin
      count_value <= wdata_i[COUNT_W-1:0];
    end
    else if (tick)
    begin
      count_value <= overflow ? RST_COUNT : COUNT_W'(count_value + 1'b1);
    end
  end

  // ****************************************
  // division value
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      division_buffer <= RST_DIV;
    end
    else if (wr_divider)
    begin
      division_buffer <= wdata_i[DIVIDE_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      division_active <= RST_DIV;
    end
    else if (update_event)
    begin
      // inhibit keeps the old ratio, since no event fires
      division_active <= division_buffer;
    end
  end

  // ****************************************
  // reload value
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      reload_preload <= RST_COUNT;
    end
    else if (wr_reload)
    begin
      reload_preload <= wdata_i[COUNT_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      reload_active <= RST_COUNT;
    end
    else if (wr_reload && !ctrl.reload_buffer_enable)
    begin
      reload_active <= wdata_i[COUNT_W-1:0];
    end
    else if (update_event)
    begin
      reload_active <= reload_preload;
    end
  end

  // ****************************************
  // requests
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      // level request, one cycle behind the flag
      irq_o <= update_pending_flag && update_irq_enable;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      dma_req_o <= 1'b0;
    end
    else
    begin
      dma_req_o <= set_pending && update_dma_enable;
    end
  end

  but_trigger_sel u_trigger (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .select_i(trigger_source_select),
    .events_i('{force_update: force_update, count_active: count_active,
                update_event: update_event}),
    .trigger_out_o(trigger_out_o)
  );

  // ****************************************
  // read path
  // ****************************************
  logic [DATA_W-1:0] next_rdata;

  always_comb
  begin
    next_rdata = RST_WORD;
    unique case (addr_i)
      OFS_CONTROL_PRIMARY:
      begin
        next_rdata[CR1_RUN_BIT] = ctrl.counter_run_enable;
        next_rdata[CR1_INHIBIT_BIT] = ctrl.update_inhibit;
        next_rdata[CR1_SOURCE_BIT] = ctrl.update_source_select;
        next_rdata[CR1_SINGLE_BIT] = ctrl.single_shot_mode;
        next_rdata[CR1_RELOAD_BUF_BIT] = ctrl.reload_buffer_enable;
      end
      OFS_CONTROL_SECONDARY:
      begin
        next_rdata[CR2_TRG_LSB +: TRG_W] = trigger_source_select;
      end
      OFS_IRQ_DMA_ENABLES:
      begin
        next_rdata[EN_IRQ_BIT] = update_irq_enable;
        next_rdata[EN_DMA_BIT] = update_dma_enable;
      end
      OFS_EVENT_FLAGS:
      begin
        next_rdata[FLAG_PENDING_BIT] = update_pending_flag;
      end
      OFS_COUNT_VALUE:
      begin
        next_rdata[COUNT_W-1:0] = count_value;
      end
      OFS_CLOCK_DIVIDER:
      begin
        next_rdata[DIVIDE_W-1:0] = division_buffer;
      end
      OFS_RELOAD_LIMIT:
      begin
        next_rdata[COUNT_W-1:0] = reload_preload;
      end
      default:
      begin
        // event trigger and unmapped offsets read as zero
        next_rdata = RST_WORD;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_o <= RST_WORD;
    end
    else if (rd_i)
    begin
      rdata_o <= next_rdata;
    end
    else
    begin
      rdata_o <= RST_WORD;
    end
  end

endmodule : but_timer
`default_nettype wire

// ===== verilog/but_trigger_sel.sv
`timescale 1ns/1ps
`default_nettype none
module but_trigger_sel
  import but_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // selection and events
  input wire logic [TRG_W-1:0] select_i,
  input wire but_evt_t events_i,
  // converter trigger
  output logic trigger_out_o
);

  logic next_trigger;

  always_comb
  begin
    next_trigger = 1'b0;
    // unlisted codes give a quiet output
    case (select_i)
      TRG_FORCE: next_trigger = events_i.force_update;
      TRG_ACTIVE: next_trigger = events_i.count_active;
      TRG_UPDATE: next_trigger = events_i.update_event;
      default: next_trigger = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      trigger_out_o <= 1'b0;
    end
    else
    begin
      trigger_out_o <= next_trigger;
    end
  end

endmodule : but_trigger_sel
`default_nettype wire
